// ### bench/test_port_phy_cable_diag_and_forced_mode_regs.sv
`timescale 1ns/100ps
module test_port_phy_cable_diag_and_forced_mode_regs
    import phy_regs_pkg::*;
;
    // Clock, reset and design-facing signals
    logic                 clk;
    logic                 reset_n;
    reg_req_s             req;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic [NUM_PORTS-1:0] strap;
    logic [NUM_PORTS-1:0] fvalid;
    logic [8:0]           fcnt [NUM_PORTS];
    phy_mode_s            pmode [NUM_PORTS];
    logic [10:0]          fdist [NUM_PORTS];
    logic                 sdone;
    // Bench bookkeeping
    int                   n_fail;
    int                   tests_run;
    int                   cycles;
    logic [7:0]           w;
    logic [8:0]           c;

    port_phy_cable_diag_and_forced_mode_regs port_phy_cable_diag_and_forced_mode_regs_inst (
        .clk(clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .an_strap_pin(strap), .fault_valid(fvalid), .fault_count(fcnt), .port_mode(pmode),
        .fault_distance_dm(fdist), .strap_done(sdone)
    );

    // Free-running clock, 4 ns period
    always #2 clk = ~clk;

    // Hang guard: far above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            end_sim();
        end
    end

    // Expected link mode: forced bits only count while negotiation is off
    function automatic logic [2:0] exp_mode(input logic [7:0] b);
        return {~b[AN_DISABLE_BIT], b[AN_DISABLE_BIT] & b[SPEED_100_BIT],
                b[AN_DISABLE_BIT] & b[FULL_DUP_BIT]};
    endfunction

    // Expected distance in decimetres: 0.4 m is four decimetres per count
    function automatic logic [10:0] exp_dist(input logic [8:0] v);
        return {v, 2'b00};
    endfunction

    // Register read data
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Single-bit status flags
    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Link mode of one port
    task automatic chk_mode(input phy_mode_s got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Fault distance of one port
    task automatic chk_dist(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register read: answer lands on the edge that takes the strobe and is checked just after it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk_flag(rvalid, 1'b1);
        chk_byte(rdata, exp);
    endtask

    // Register write: one-cycle strobe, settled just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask

    // One diagnostic result pulse on a port
    task automatic pulse(input int p, input logic [8:0] v);
        @(posedge clk);
        fvalid[p] <= 1'b1;
        fcnt[p] <= v;
        @(posedge clk);
        fvalid[p] <= 1'b0;
        #1;
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("TB: checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Reset and strap capture, then per-port register traffic
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        req = '0;
        fvalid = '0;
        cycles = 0;
        n_fail = 0;
        tests_run = 0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            fcnt[p] = 9'h000;
        end
        w = 8'($urandom(32'he84d3f7a));
        strap = 4'($urandom());
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk_flag(sdone, 1'b1);
        for (int p = 0; p < NUM_PORTS; p++) begin
            rd(CTRL_OFF[p], {~strap[p], 7'h00});
            chk_mode(pmode[p], {strap[p], 2'b00});
            rd(FAULT_LOW_OFF[p], REG_ZERO);
            c = (p == 0) ? 9'h1ff : 9'($urandom());
            pulse(p, c);
            chk_dist(fdist[p], exp_dist(c));
            rd(FAULT_LOW_OFF[p], c[7:0]);
            rd(FAULT_MSB_OFF[p], {7'h00, c[8]});
            wr(FAULT_LOW_OFF[p], ~c[7:0]);
            rd(FAULT_LOW_OFF[p], c[7:0]);
            // Every combination of the three mode bits, then one fully random byte
            for (int m = 0; m < 9; m++) begin
                w = (m < 8) ? {m[2:0], 5'($urandom())} : 8'($urandom());
                wr(CTRL_OFF[p], w);
                chk_mode(pmode[p], exp_mode(w));
                rd(CTRL_OFF[p], w & 8'he0);
            end
        end
        // Reserved and unmapped places
        wr(RSVD_CTRL_OFF, 8'hff);
        rd(RSVD_CTRL_OFF, REG_ZERO);
        rd(RSVD_FAULT_OFF, REG_ZERO);
        rd(8'h1d, REG_ZERO);
        // Second reset mid-run, straps flipped, brings back strap value and cleared counts
        @(posedge clk);
        strap <= ~strap;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk_flag(sdone, 1'b0);
        chk_mode(pmode[0], 3'b100);
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(CTRL_OFF[0], {~strap[0], 7'h00});
        rd(FAULT_LOW_OFF[0], REG_ZERO);
        rd(FAULT_MSB_OFF[0], REG_ZERO);
        end_sim();
    end
endmodule

// ### common/phy_regs_pkg.sv
package phy_regs_pkg;

    // Port count of this slice
    localparam int NUM_PORTS = 4;

    // Register offsets on the management register port
    localparam logic [7:0] FAULT_MSB_OFF [NUM_PORTS] = '{8'h1a, 8'h2a, 8'h3a, 8'h4a};
    localparam logic [7:0] FAULT_LOW_OFF [NUM_PORTS] = '{8'h1b, 8'h2b, 8'h3b, 8'h4b};
    localparam logic [7:0] CTRL_OFF      [NUM_PORTS] = '{8'h1c, 8'h2c, 8'h3c, 8'h4c};
    localparam logic [7:0] RSVD_FAULT_OFF           = 8'h5b;
    localparam logic [7:0] RSVD_CTRL_OFF            = 8'h5c;

    // Control and fault MSB register field positions
    localparam int AN_DISABLE_BIT = 7;
    localparam int SPEED_100_BIT  = 6;
    localparam int FULL_DUP_BIT   = 5;
    localparam int FAULT_MSB_BIT  = 0;

    // Reset values
    localparam logic [7:0] REG_ZERO     = 8'h00;
    localparam logic [8:0] FAULT_RESET  = 9'h000;
    localparam logic [2:0] MODE_RESET   = 3'h0;

    // Fault distance scale: 0.4 m per count, held as decimetres per count
    localparam logic [10:0] FAULT_DM_PER_COUNT = 11'h004;

    // Forced mode and link-side configuration of one port
    typedef struct packed {
        logic an_enable;
        logic speed_100;
        logic full_duplex;
    } phy_mode_s;

    // Management register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Strap capture sequence after reset release
    typedef enum logic [1:0] {
        STRAP_WAIT0 = 2'b00,
        STRAP_WAIT1 = 2'b01,
        STRAP_LOAD  = 2'b10,
        STRAP_DONE  = 2'b11
    } strap_state_e;

endpackage

// ### rtl/port_mode_slice.sv
`timescale 1ns/100ps
module port_mode_slice
    import phy_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // Strap load
    input  wire logic                    strap_load,
    input  wire logic                    strap_level,
    // Register writes
    input  wire logic                    ctrl_wr,
    input  wire logic [7:0]              ctrl_wdata,
    // Diagnostic engine result
    input  wire logic                    fault_valid,
    input  wire logic [8:0]              fault_count,
    // Register views and mode
    output logic [7:0]                   ctrl_byte,
    output logic [8:0]                   fault_count_q,
    output logic [10:0]                  fault_distance_dm,
    output phy_regs_pkg::phy_mode_s      mode
);
    import phy_regs_pkg::*;

    logic [2:0] ctrl_q;   // {an_disable, speed_100, full_duplex}

    // Control bits; a software write wins over the one-time strap load
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= MODE_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= ctrl_wdata[AN_DISABLE_BIT:FULL_DUP_BIT];
        end else if (strap_load) begin
            ctrl_q[2] <= ~strap_level;
        end
    end

    // Latest fault count from the diagnostic engine
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_count_q <= FAULT_RESET;
        end else if (fault_valid) begin
            fault_count_q <= fault_count;
        end
    end

    // Register view and derived mode
    always_comb begin
        ctrl_byte                 = REG_ZERO;
        ctrl_byte[AN_DISABLE_BIT] = ctrl_q[2];
        ctrl_byte[SPEED_100_BIT]  = ctrl_q[1];
        ctrl_byte[FULL_DUP_BIT]   = ctrl_q[0];
        mode.an_enable   = ~ctrl_q[2];
        mode.speed_100   = ctrl_q[2] & ctrl_q[1];
        mode.full_duplex = ctrl_q[2] & ctrl_q[0];
    end

    // Distance in decimetres for the cable fault
    assign fault_distance_dm = 11'(fault_count_q) * FAULT_DM_PER_COUNT;

    chk_fault_capture_value: assert property (
        @(posedge clk) disable iff (!reset_n)
        fault_valid |=> fault_count_q == $past(fault_count))
        else $error("fault count not captured");

    chk_distance_scale_value: assert property (
        @(posedge clk) disable iff (!reset_n)
        fault_distance_dm == {fault_count_q, 2'b00})
        else $error("fault distance not four decimetres per count");

    chk_duplex_ignored_auto: assert property (
        @(posedge clk) disable iff (!reset_n)
        mode.an_enable |-> !mode.full_duplex && !mode.speed_100)
        else $error("forced bits leak while auto-negotiation runs");

endmodule

// ### rtl/port_phy_cable_diag_and_forced_mode_regs.sv
`timescale 1ns/100ps
module port_phy_cable_diag_and_forced_mode_regs
    import phy_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                reset_n,
    // Management register port
    input  wire phy_regs_pkg::reg_req_s              reg_req,
    output logic [7:0]                               reg_rdata,
    output logic                                     reg_rvalid,
    // Auto-negotiation enable straps, one per port (high leaves negotiation on)
    input  wire logic [phy_regs_pkg::NUM_PORTS-1:0]  an_strap_pin,
    // Cable diagnostic engine results
    input  wire logic [phy_regs_pkg::NUM_PORTS-1:0]  fault_valid,
    input  wire logic [8:0]                          fault_count [phy_regs_pkg::NUM_PORTS],
    // Per-port link configuration
    output phy_regs_pkg::phy_mode_s                  port_mode [phy_regs_pkg::NUM_PORTS],
    output logic [10:0]                              fault_distance_dm [phy_regs_pkg::NUM_PORTS],
    output logic                                     strap_done
);
    import phy_regs_pkg::*;

    logic [NUM_PORTS-1:0] strap_meta_q;
    logic [NUM_PORTS-1:0] strap_sync_q;
    strap_state_e         strap_state_q;
    logic [NUM_PORTS-1:0] ctrl_wr;
    logic [7:0]           ctrl_byte [NUM_PORTS];
    logic [8:0]           fault_q [NUM_PORTS];
    logic [7:0]           rdata_d;

    // Strap pins come from outside: two flops before use
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_meta_q <= '0;
            strap_sync_q <= '0;
        end else begin
            strap_meta_q <= an_strap_pin;
            strap_sync_q <= strap_meta_q;
        end
    end

    // Waits for the synchroniser to fill, then loads straps once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_state_q <= STRAP_WAIT0;
        end else begin
            unique case (strap_state_q)
                STRAP_WAIT0: strap_state_q <= STRAP_WAIT1;
                STRAP_WAIT1: strap_state_q <= STRAP_LOAD;
                STRAP_LOAD:  strap_state_q <= STRAP_DONE;
                STRAP_DONE:  strap_state_q <= STRAP_DONE;
            endcase
        end
    end

    assign strap_done = (strap_state_q == STRAP_DONE);

    // One slice per port
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            // Reserved 0x5C never matches a port offset
            assign ctrl_wr[p] = reg_req.wr && (reg_req.addr == CTRL_OFF[p]);

            port_mode_slice u_slice (
                .clk               (clk),
                .reset_n           (reset_n),
                .strap_load        (strap_state_q == STRAP_LOAD),
                .strap_level       (strap_sync_q[p]),
                .ctrl_wr           (ctrl_wr[p]),
                .ctrl_wdata        (reg_req.wdata),
                .fault_valid       (fault_valid[p]),
                .fault_count       (fault_count[p]),
                .ctrl_byte         (ctrl_byte[p]),
                .fault_count_q     (fault_q[p]),
                .fault_distance_dm (fault_distance_dm[p]),
                .mode              (port_mode[p])
            );

            chk_fault_low_read: assert property (
                @(posedge clk) disable iff (!reset_n)
                reg_req.rd && reg_req.addr == FAULT_LOW_OFF[p]
                |=> reg_rvalid && reg_rdata == $past(fault_q[p][7:0]))
                else $error("fault low byte read mismatch");

            chk_fault_msb_read: assert property (
                @(posedge clk) disable iff (!reset_n)
                reg_req.rd && reg_req.addr == FAULT_MSB_OFF[p]
                |=> reg_rdata == {7'h00, $past(fault_q[p][8])})
                else $error("fault count top bit read mismatch");

            chk_ctrl_write_read: assert property (
                @(posedge clk) disable iff (!reset_n)
                reg_req.wr && reg_req.addr == CTRL_OFF[p] ##1
                reg_req.rd && !reg_req.wr && reg_req.addr == CTRL_OFF[p]
                |=> reg_rdata == {$past(reg_req.wdata, 2) & 8'he0})
                else $error("control register write then read mismatch");

            chk_an_disable_mode: assert property (
                @(posedge clk) disable iff (!reset_n)
                port_mode[p].an_enable == !ctrl_byte[p][AN_DISABLE_BIT]
                && (port_mode[p].an_enable
                    || (port_mode[p].speed_100 == ctrl_byte[p][SPEED_100_BIT]
                        && port_mode[p].full_duplex == ctrl_byte[p][FULL_DUP_BIT])))
                else $error("forced mode does not follow control bits");

            chk_strap_inverse_load: assert property (
                @(posedge clk) disable iff (!reset_n)
                strap_state_q == STRAP_LOAD && !ctrl_wr[p]
                |=> ctrl_byte[p][AN_DISABLE_BIT] == !$past(strap_sync_q[p]))
                else $error("strap not loaded inverted");

            // Writes are taken from the first edge on, so only the first state is untouched
            chk_speed_reset_zero: assert property (
                @(posedge clk) disable iff (!reset_n)
                strap_state_q == STRAP_WAIT0 |-> !ctrl_byte[p][SPEED_100_BIT])
                else $error("speed bit not zero after reset");

            // Control bits move only on a write to this port or the strap load
            chk_ctrl_holds_idle: assert property (
                @(posedge clk) disable iff (!reset_n)
                !ctrl_wr[p] && strap_state_q != STRAP_LOAD |=> $stable(ctrl_byte[p]))
                else $error("control bits moved without a write");

            // A write sets the negotiation mode one cycle after the strobe
            chk_write_sets_mode: assert property (
                @(posedge clk) disable iff (!reset_n)
                ctrl_wr[p] |=> port_mode[p].an_enable != $past(reg_req.wdata[AN_DISABLE_BIT]))
                else $error("write did not set negotiation mode");

            // Unused control bits read zero
            chk_ctrl_low_zero: assert property (
                @(posedge clk) disable iff (!reset_n)
                ctrl_byte[p][FULL_DUP_BIT-1:0] == '0)
                else $error("unused control bits not zero");

            // The stored count changes only on a result from the engine
            chk_fault_holds_idle: assert property (
                @(posedge clk) disable iff (!reset_n)
                !fault_valid[p] |=> $stable(fault_q[p]))
                else $error("fault count moved without a result");
        end
    endgenerate

    // Read mux; unmapped and reserved offsets read zero
    always_comb begin
        rdata_d = REG_ZERO;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (reg_req.addr == FAULT_LOW_OFF[i]) begin
                rdata_d = fault_q[i][7:0];
            end
            if (reg_req.addr == FAULT_MSB_OFF[i]) begin
                rdata_d[FAULT_MSB_BIT] = fault_q[i][8];
            end
            if (reg_req.addr == CTRL_OFF[i]) begin
                rdata_d = ctrl_byte[i];
            end
        end
    end

    // Read data is registered, valid one cycle after the request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= REG_ZERO;
        end else if (reg_req.rd) begin
            reg_rdata <= rdata_d;
        end
    end

    // Read answer strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
        end
    end

    chk_read_answer_timing: assert property (
        @(posedge clk) disable iff (!reset_n)
        reg_req.rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_req.rd)))
        else $error("read answer not one cycle after request");

    chk_reserved_reads_zero: assert property (
        @(posedge clk) disable iff (!reset_n)
        reg_req.rd && (reg_req.addr == RSVD_FAULT_OFF || reg_req.addr == RSVD_CTRL_OFF)
        |=> reg_rdata == REG_ZERO)
        else $error("reserved offset reads nonzero");

    chk_strap_sequence_len: assert property (
        @(posedge clk) disable iff (!reset_n)
        strap_state_q == STRAP_WAIT0 |=> strap_state_q == STRAP_WAIT1
        ##1 strap_state_q == STRAP_LOAD ##1 strap_done)
        else $error("strap load sequence out of order");

    // Read data stands until the next read
    chk_rdata_holds_idle: assert property (
        @(posedge clk) disable iff (!reset_n)
        !reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // The answer strobe stands only in the cycle after a read request
    chk_rvalid_one_cycle: assert property (
        @(posedge clk) disable iff (!reset_n)
        !reg_req.rd |=> !reg_rvalid)
        else $error("read answer strobe without a read");

    // Strap capture happens once and stays done
    chk_strap_done_holds: assert property (
        @(posedge clk) disable iff (!reset_n)
        strap_done |=> strap_done)
        else $error("strap done dropped");

endmodule
